// ---- src/clp_pkg.sv ----
// Shared constants, register map and types for the cold load pickup block
package clp_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 5_000; // Processing tick, 5 ms
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int DELAY_W = 20; // Delays in ticks, 1800 s fits
	localparam logic [19:0] START_DELAY_RST = 20'h007d0; // 10.000 s = 2000 ticks
	localparam logic [19:0] MAX_DELAY_RST = 20'h01770; // 30.000 s = 6000 ticks
	localparam logic [19:0] MIN_HOLD_RST = 20'h00008; // 0.040 s = 8 ticks
	// ==========================================================
	// Current magnitudes, hundredths of nominal
	localparam int CUR_W = 16;
	localparam logic [15:0] LOW_THR_RST = 16'h0014; // 0.20 x In
	localparam logic [15:0] HIGH_THR_RST = 16'h0078; // 1.20 x In
	localparam logic [15:0] OVER_THR_RST = 16'h00c8; // 2.00 x In
	localparam int RATIO_NUM = 97;
	localparam int RATIO_DEN = 100;
	// ==========================================================
	// Register byte offsets (AXI4-Lite)
	localparam logic [7:0] REG_CTRL = 8'h00; // [0] counter clear, [1] log clear (self-clearing)
	localparam logic [7:0] REG_START_DELAY = 8'h04;
	localparam logic [7:0] REG_MAX_DELAY = 8'h08;
	localparam logic [7:0] REG_MIN_HOLD = 8'h0c;
	localparam logic [7:0] REG_LOW_THR = 8'h10;
	localparam logic [7:0] REG_HIGH_THR = 8'h14;
	localparam logic [7:0] REG_OVER_THR = 8'h18;
	localparam logic [7:0] REG_EVT_SEL = 8'h1c; // [2k]=ON enable, [2k+1]=OFF enable
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_ACT_CNT = 8'h24;
	localparam logic [7:0] REG_BLK_CNT = 8'h28;
	localparam logic [7:0] REG_LOG_IDX = 8'h2c; // Write selects entry, read gives write pointer [7:4] and count [3:0]
	localparam logic [7:0] REG_LOG_W0 = 8'h30; // Time stamp
	localparam logic [7:0] REG_LOG_W1 = 8'h34; // [3:0] event, [7:4] group
	localparam logic [7:0] REG_LOG_W2 = 8'h38; // L1 | L2<<16
	localparam logic [7:0] REG_LOG_W3 = 8'h3c; // L3
	localparam logic [7:0] REG_LOG_W4 = 8'h40; // Time to activation
	localparam logic [7:0] REG_LOG_W5 = 8'h44; // Active time
	localparam logic [7:0] REG_LOG_W6 = 8'h48; // Start-up time
	localparam logic [7:0] REG_LOG_W7 = 8'h4c; // Reclaim counter
	localparam logic [11:0] EVT_SEL_RST = 12'hfff;
	localparam int LOG_DEPTH = 12;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ==========================================================
	// Events: low start, high start, load normal, overcurrent, activation, block
	localparam int N_EVT = 6;
	localparam int EVT_ACT = 4;
	localparam int EVT_BLK = 5;
	typedef enum logic [4:0] {
		CLP_IDLE = 5'b00001,
		CLP_LOW = 5'b00010,
		CLP_ACTIVE = 5'b00100,
		CLP_HIGH = 5'b01000,
		CLP_BLOCKED = 5'b10000
	} clp_state_e;
	typedef struct packed {
		logic [31:0] stamp;
		logic [3:0] evt;
		logic [3:0] group;
		logic [15:0] i1, i2, i3;
		logic [19:0] to_act, act_time, start_time, reclaim;
	} clp_log_s;
endpackage : clp_pkg

// ---- src/clp_cmp.sv ----
// Threshold comparator on three phases, with hysteresis only in the above-setting (ABOVE) mode
`timescale 1ns/1ps
module clp_cmp
	import clp_pkg::*;
#(
	parameter bit ABOVE = 1'b1,
	parameter bit ANY = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic [CUR_W-1:0] i1,
	input wire logic [CUR_W-1:0] i2,
	input wire logic [CUR_W-1:0] i3,
	input wire logic [CUR_W-1:0] thr,
	output logic hit
);
	logic [CUR_W-1:0] rel;
	logic [2:0] on;
	logic [2:0] off;
	logic [CUR_W+7:0] scaled;

	// Drop-out level at 97 % of setting
	assign scaled = ({8'h00, thr} * (CUR_W+8)'(RATIO_NUM)) / (CUR_W+8)'(RATIO_DEN);
	assign rel = scaled[CUR_W-1:0];

	// Pickup above setting, drop out below the reset level; under picks up below and drops out above the setting
	function automatic logic pick(input logic [CUR_W-1:0] x, input logic [CUR_W-1:0] t);
		pick = ABOVE ? (x > t) : (x < t);
	endfunction : pick
	assign on = {pick(i3, thr), pick(i2, thr), pick(i1, thr)};
	assign off = ABOVE ? {i3 < rel, i2 < rel, i1 < rel} : {i3 > thr, i2 > thr, i1 > thr};

	// Evaluated once per tick; any/all across phases
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit <= 1'b0;
		end else if (tick) begin
			if (ANY) begin
				hit <= hit ? ~&off : |on;
			end else begin
				hit <= hit ? ~|off : &on;
			end
		end
	end
endmodule : clp_cmp

// ---- src/clp_core.sv ----
// Cold load pickup timing core with AXI4-Lite registers, events and log
`timescale 1ns/1ps
module clp_core
	import clp_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [CUR_W-1:0] i_l1,
	input wire logic [CUR_W-1:0] i_l2,
	input wire logic [CUR_W-1:0] i_l3,
	input wire logic block_in,
	input wire logic [3:0] setting_group,
	input wire logic [31:0] time_stamp,
	output logic cold_load_active,
	output logic blocked,
	output logic [N_EVT-1:0] evt_on,
	output logic [N_EVT-1:0] evt_off,
	output logic [31:0] evt_stamp
);
	// ==========================================================
	// Registers
	logic [DELAY_W-1:0] start_delay, max_delay, min_hold_delay;
	logic [CUR_W-1:0] low_current_threshold, high_current_threshold, overcurrent_threshold;
	logic [2*N_EVT-1:0] evt_sel;
	logic [31:0] act_cnt, blk_cnt;
	logic cnt_clr, log_clr;
	logic [3:0] log_sel, log_wp, log_cnt;
	clp_log_s log_mem [LOG_DEPTH];
	logic [31:0] tick_cnt;
	logic tick;
	logic blk_s1, blk_s2;
	logic low_hit, high_hit, over_hit;
	clp_state_e state;
	logic [DELAY_W-1:0] t_low, t_max, t_min, t_act;
	logic up_done;
	logic [N_EVT-1:0] cond, cond_q;

	// Apply byte strobes to a register word
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				old[8*b +: 8] = d[8*b +: 8];
			end
		end
		wmerge = old;
	endfunction : wmerge

	// Saturating tick increment
	function automatic logic [DELAY_W-1:0] inc(input logic [DELAY_W-1:0] v);
		inc = (&v) ? v : v + 1'b1;
	endfunction : inc

	// ==========================================================
	// Processing tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= (tick_cnt == 32'(TICK_DIV - 1)) ? '0 : tick_cnt + 1'b1;
		end
	end
	assign tick = (tick_cnt == 32'(TICK_DIV - 1));

	// Block comes from the matrix on another timing; synchronise it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blk_s1 <= 1'b0;
			blk_s2 <= 1'b0;
		end else begin
			blk_s1 <= block_in;
			blk_s2 <= blk_s1;
		end
	end

	// ==========================================================
	// Comparators
	clp_cmp #(.ABOVE(1'b0), .ANY(1'b0)) u_low (.aclk(aclk), .aresetn(aresetn), .tick(tick),
		.i1(i_l1), .i2(i_l2), .i3(i_l3), .thr(low_current_threshold), .hit(low_hit));
	clp_cmp #(.ABOVE(1'b1), .ANY(1'b0)) u_high (.aclk(aclk), .aresetn(aresetn), .tick(tick),
		.i1(i_l1), .i2(i_l2), .i3(i_l3), .thr(high_current_threshold), .hit(high_hit));
	clp_cmp #(.ABOVE(1'b1), .ANY(1'b1)) u_over (.aclk(aclk), .aresetn(aresetn), .tick(tick),
		.i1(i_l1), .i2(i_l2), .i3(i_l3), .thr(overcurrent_threshold), .hit(over_hit));

	// ==========================================================
	// Sequence; state moves only on ticks so all timing is in whole ticks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= CLP_IDLE;
			t_low <= '0;
			t_max <= '0;
			t_min <= '0;
			t_act <= '0;
			up_done <= 1'b0;
		end else if (tick) begin
			case (state)
				CLP_IDLE: begin
					t_low <= '0;
					if (low_hit) begin
						state <= CLP_LOW;
					end
				end
				CLP_LOW: begin
					if (!low_hit) begin
						state <= CLP_IDLE;
					end else if (t_low >= start_delay) begin
						state <= blk_s2 ? CLP_BLOCKED : CLP_ACTIVE;
						t_min <= '0;
						t_act <= '0;
						up_done <= 1'b0;
					end else begin
						t_low <= inc(t_low);
					end
				end
				CLP_ACTIVE: begin
					// Hold window, also the reclaim time for a late inrush
					t_act <= inc(t_act);
					if (over_hit || blk_s2) begin
						state <= CLP_IDLE;
					end else if (high_hit) begin
						state <= CLP_HIGH;
						t_max <= '0;
					end else if (!low_hit && t_min >= min_hold_delay) begin
						state <= CLP_IDLE;
					end else if (!low_hit) begin
						t_min <= inc(t_min);
					end
				end
				CLP_HIGH: begin
					t_act <= inc(t_act);
					t_max <= inc(t_max);
					if (over_hit || blk_s2) begin
						state <= CLP_IDLE;
					end else if (t_max >= max_delay) begin
						state <= CLP_IDLE;
					end else if (!high_hit) begin
						state <= CLP_ACTIVE;
						up_done <= 1'b1;
						t_min <= '0;
					end
				end
				CLP_BLOCKED: begin
					if (!low_hit) begin
						state <= CLP_IDLE;
					end
				end
				default: state <= CLP_IDLE;
			endcase
		end
	end

	assign cold_load_active = (state == CLP_ACTIVE) || (state == CLP_HIGH);
	assign blocked = (state == CLP_BLOCKED);

	// ==========================================================
	// Events: edges of six conditions, filtered per direction
	assign cond = {blocked, cold_load_active, over_hit, up_done && cold_load_active,
		high_hit && cold_load_active, low_hit};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_q <= '0;
			evt_on <= '0;
			evt_off <= '0;
			evt_stamp <= '0;
		end else begin
			cond_q <= cond;
			for (int k = 0; k < N_EVT; k++) begin
				evt_on[k] <= cond[k] & ~cond_q[k] & evt_sel[2*k];
				evt_off[k] <= ~cond[k] & cond_q[k] & evt_sel[2*k+1];
			end
			if (cond != cond_q) begin
				evt_stamp <= time_stamp;
			end
		end
	end

	// Counters; a new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_cnt <= '0;
			blk_cnt <= '0;
		end else begin
			if (cond[EVT_ACT] && !cond_q[EVT_ACT]) begin
				act_cnt <= cnt_clr ? 32'h00000001 : act_cnt + 1'b1;
			end else if (cnt_clr) begin
				act_cnt <= '0;
			end
			if (cond[EVT_BLK] && !cond_q[EVT_BLK]) begin
				blk_cnt <= cnt_clr ? 32'h00000001 : blk_cnt + 1'b1;
			end else if (cnt_clr) begin
				blk_cnt <= '0;
			end
		end
	end

	// ==========================================================
	// Rolling log, one entry per cycle with ON edges (lowest event kept); oldest overwritten once full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			log_wp <= '0;
			log_cnt <= '0;
			for (int j = 0; j < LOG_DEPTH; j++) begin
				log_mem[j] <= '0;
			end
		end else if (|(cond & ~cond_q)) begin
			for (int k = N_EVT - 1; k >= 0; k--) begin
				if (cond[k] && !cond_q[k]) begin
					log_mem[log_wp].evt <= 4'(k);
				end
			end
			log_mem[log_wp].stamp <= time_stamp;
			log_mem[log_wp].group <= setting_group;
			log_mem[log_wp].i1 <= i_l1;
			log_mem[log_wp].i2 <= i_l2;
			log_mem[log_wp].i3 <= i_l3;
			log_mem[log_wp].to_act <= (start_delay > t_low) ? start_delay - t_low : '0;
			log_mem[log_wp].act_time <= t_act;
			log_mem[log_wp].start_time <= t_max;
			log_mem[log_wp].reclaim <= t_min;
			log_wp <= (log_wp == 4'(LOG_DEPTH - 1)) ? '0 : log_wp + 1'b1;
			log_cnt <= (log_cnt == 4'(LOG_DEPTH)) ? log_cnt : log_cnt + 1'b1;
		end else if (log_clr) begin
			log_cnt <= '0;
			log_wp <= '0;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel; address and data may come in either order
	logic aw_held, w_held;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic wr_go;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_go = aw_held && w_held;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q > REG_LOG_IDX) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Setting registers; strobes self-clear after one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_delay <= START_DELAY_RST;
			max_delay <= MAX_DELAY_RST;
			min_hold_delay <= MIN_HOLD_RST;
			low_current_threshold <= LOW_THR_RST;
			high_current_threshold <= HIGH_THR_RST;
			overcurrent_threshold <= OVER_THR_RST;
			evt_sel <= EVT_SEL_RST;
			cnt_clr <= 1'b0;
			log_clr <= 1'b0;
			log_sel <= '0;
		end else begin
			cnt_clr <= 1'b0;
			log_clr <= 1'b0;
			if (wr_go) begin
				if (aw_q == REG_CTRL) begin
					cnt_clr <= wd_q[0] & ws_q[0];
					log_clr <= wd_q[1] & ws_q[0];
				end else if (aw_q == REG_START_DELAY) begin
					start_delay <= DELAY_W'(wmerge(32'(start_delay), wd_q, ws_q));
				end else if (aw_q == REG_MAX_DELAY) begin
					max_delay <= DELAY_W'(wmerge(32'(max_delay), wd_q, ws_q));
				end else if (aw_q == REG_MIN_HOLD) begin
					min_hold_delay <= DELAY_W'(wmerge(32'(min_hold_delay), wd_q, ws_q));
				end else if (aw_q == REG_LOW_THR) begin
					low_current_threshold <= CUR_W'(wmerge(32'(low_current_threshold), wd_q, ws_q));
				end else if (aw_q == REG_HIGH_THR) begin
					high_current_threshold <= CUR_W'(wmerge(32'(high_current_threshold), wd_q, ws_q));
				end else if (aw_q == REG_OVER_THR) begin
					overcurrent_threshold <= CUR_W'(wmerge(32'(overcurrent_threshold), wd_q, ws_q));
				end else if (aw_q == REG_EVT_SEL) begin
					evt_sel <= (2*N_EVT)'(wmerge(32'(evt_sel), wd_q, ws_q));
				end else if (aw_q == REG_LOG_IDX) begin
					log_sel <= (wd_q[3:0] < 4'(LOG_DEPTH)) ? wd_q[3:0] : log_sel;
				end
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel, one cycle after the address is taken
	clp_log_s le;
	assign le = log_mem[log_sel];
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			if (s_axi_araddr[7:0] == REG_CTRL) s_axi_rdata <= '0;
			else if (s_axi_araddr[7:0] == REG_START_DELAY) s_axi_rdata <= 32'(start_delay);
			else if (s_axi_araddr[7:0] == REG_MAX_DELAY) s_axi_rdata <= 32'(max_delay);
			else if (s_axi_araddr[7:0] == REG_MIN_HOLD) s_axi_rdata <= 32'(min_hold_delay);
			else if (s_axi_araddr[7:0] == REG_LOW_THR) s_axi_rdata <= 32'(low_current_threshold);
			else if (s_axi_araddr[7:0] == REG_HIGH_THR) s_axi_rdata <= 32'(high_current_threshold);
			else if (s_axi_araddr[7:0] == REG_OVER_THR) s_axi_rdata <= 32'(overcurrent_threshold);
			else if (s_axi_araddr[7:0] == REG_EVT_SEL) s_axi_rdata <= 32'(evt_sel);
			else if (s_axi_araddr[7:0] == REG_STATUS) s_axi_rdata <= {24'h000000, blk_s2, over_hit,
				high_hit, low_hit, 3'(state[4:2]) == 3'h0 ? 1'b0 : 1'b1, state[2:0] == 3'h0, 2'(state[1:0])};
			else if (s_axi_araddr[7:0] == REG_ACT_CNT) s_axi_rdata <= act_cnt;
			else if (s_axi_araddr[7:0] == REG_BLK_CNT) s_axi_rdata <= blk_cnt;
			else if (s_axi_araddr[7:0] == REG_LOG_IDX) s_axi_rdata <= {24'h000000, log_wp, log_cnt};
			else if (s_axi_araddr[7:0] == REG_LOG_W0) s_axi_rdata <= le.stamp;
			else if (s_axi_araddr[7:0] == REG_LOG_W1) s_axi_rdata <= {24'h000000, le.group, le.evt};
			else if (s_axi_araddr[7:0] == REG_LOG_W2) s_axi_rdata <= {le.i2, le.i1};
			else if (s_axi_araddr[7:0] == REG_LOG_W3) s_axi_rdata <= 32'(le.i3);
			else if (s_axi_araddr[7:0] == REG_LOG_W4) s_axi_rdata <= 32'(le.to_act);
			else if (s_axi_araddr[7:0] == REG_LOG_W5) s_axi_rdata <= 32'(le.act_time);
			else if (s_axi_araddr[7:0] == REG_LOG_W6) s_axi_rdata <= 32'(le.start_time);
			else if (s_axi_araddr[7:0] == REG_LOG_W7) s_axi_rdata <= 32'(le.reclaim);
			else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	sequence s_tick_exit_over;
		tick && cold_load_active && over_hit;
	endsequence
	AST_OVER_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_tick_exit_over |=> !cold_load_active) else $error("overcurrent did not release");
	AST_MAX_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_HIGH && t_max >= max_delay |=> !cold_load_active)
		else $error("max delay did not release");
	AST_EARLY_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_LOW && !low_hit |=> state == CLP_IDLE)
		else $error("low ended but not idle");
	AST_ACT_AFTER_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cold_load_active) |-> $past(t_low) >= start_delay)
		else $error("activated before start delay");
	AST_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_LOW && low_hit && t_low >= start_delay && blk_s2 |=> blocked
		&& !cold_load_active) else $error("block did not stop activation");
	AST_HIGH_START: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_ACTIVE && high_hit && !over_hit && !blk_s2 |=> state == CLP_HIGH
		&& t_max == '0) else $error("max timer not started");
	AST_ACT_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		cond[EVT_ACT] && !cond_q[EVT_ACT] && !cnt_clr |=> act_cnt == $past(act_cnt) + 1)
		else $error("activation count missed");
	AST_LOG_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		log_wp < 4'(LOG_DEPTH) && log_cnt <= 4'(LOG_DEPTH)) else $error("log pointer out of range");
	AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_ACTIVE && !low_hit && !high_hit && !over_hit && !blk_s2
		&& t_min < min_hold_delay |=> cold_load_active) else $error("released before hold");
	AST_STARTUP_END: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_HIGH && !high_hit && !over_hit && !blk_s2 && t_max < max_delay
		|=> state == CLP_ACTIVE && up_done) else $error("start-up end not taken");
	AST_NO_INRUSH: assert property (@(posedge aclk) disable iff (!aresetn)
		tick && state == CLP_ACTIVE && !low_hit && !high_hit && !over_hit && !blk_s2
		&& t_min >= min_hold_delay |=> !cold_load_active) else $error("hold did not end");
endmodule : clp_core

// ---- testbench/clp_meas_model.sv ----
// Phase current source and blocking matrix stand-in for the bench
`timescale 1ns/1ps
module clp_meas_model
	import clp_pkg::*;
(
	input wire logic aclk,
	input wire logic [1:0] lvl,
	input wire logic blk_req,
	output logic [CUR_W-1:0] i_l1,
	output logic [CUR_W-1:0] i_l2,
	output logic [CUR_W-1:0] i_l3,
	output logic block_in
);
	// ==========================================================
	// Levels: 0 low, 1 between thresholds, 2 high, 3 overcurrent on one phase
	logic [CUR_W-1:0] base;
	assign base = (lvl == 2'h0) ? 16'h000a : (lvl == 2'h1) ? 16'h003c : 16'h0096;
	// Phases differ slightly so all-phase and any-phase logic is not trivial
	always_ff @(posedge aclk) begin
		i_l1 <= base;
		i_l2 <= base + 16'h0001;
		i_l3 <= (lvl == 2'h3) ? 16'h00fa : base + 16'h0002; // Only L3 over
		block_in <= blk_req;
	end
endmodule : clp_meas_model

// ---- testbench/cold_load_pickup_timing_bench.sv ----
// Self-checking bench for the cold load pickup core
`timescale 1ns/1ps
module cold_load_pickup_timing_bench
	import clp_pkg::*;
;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, act, blocked, block_in, blk_req = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, stamp = 0;
	logic [1:0] bresp, rresp, lvl = 2'h1;
	logic [CUR_W-1:0] i1, i2, i3;
	logic [N_EVT-1:0] evt_on, evt_off;
	logic [31:0] evt_stamp, stamp_gap = 32'h0;
	logic [2*N_EVT-1:0] evt_seen = 12'h000;
	int error_cnt = 0, num_checks = 0;
	// ==========================================================
	// Clock and a running time stamp
	initial begin
		forever #5 aclk = ~aclk;
	end
	always_ff @(posedge aclk) stamp <= stamp + 32'h1;
	// Sticky record of event pulses; gated so pre-reset unknowns never stick
	always_ff @(posedge aclk) begin
		if (aresetn) begin
			evt_seen <= evt_seen | {evt_off, evt_on};
			if (evt_off[EVT_ACT]) stamp_gap <= stamp - evt_stamp;
		end
	end
	// Short tick keeps timer counts small
	clp_core #(.TICK_DIV(10)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.i_l1(i1), .i_l2(i2), .i_l3(i3), .block_in(block_in), .setting_group(4'h1),
		.time_stamp(stamp), .cold_load_active(act), .blocked(blocked), .evt_on(evt_on),
		.evt_off(evt_off), .evt_stamp(evt_stamp));
	clp_meas_model meas (.aclk(aclk), .lvl(lvl), .blk_req(blk_req), .i_l1(i1), .i_l2(i2),
		.i_l3(i3), .block_in(block_in));
	// ==========================================================
	// Reporting
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	// ==========================================================
	// Bus cycles; ready is sampled mid-cycle, so it reflects the coming edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		bit ta, tw, tb;
		n = 0;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end while (!tb && n < 40);
		bready <= 1'b0;
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, tb ? bresp : 2'h3});
		if (!tb) complete_run();
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
		input string w);
		int n;
		bit ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		n = 0;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end while (!tr && n < 40);
		rready <= 1'b0;
		chk(w, e, d);
		chk(w, {30'h0, er}, {30'h0, tr ? r : 2'h3});
		if (!tr) complete_run();
	endtask : rdc
	// Wait up to n cycles for {blocked, active} to reach e, or check it holds for n
	task automatic watch(input logic [1:0] e, input int n, input bit upto, input string w);
		int k;
		for (k = 0; k < n && (({blocked, act} === e) != upto); k++) @(negedge aclk);
		chk(w, {30'h0, e}, {30'h0, blocked, act});
		if (upto && {blocked, act} !== e) complete_run();
	endtask : watch
	task automatic go(input logic [1:0] l, input int n);
		@(posedge aclk) lvl <= l;
		repeat (n) @(posedge aclk);
	endtask : go
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rdc(REG_START_DELAY, START_DELAY_RST, RESP_OKAY, "start delay");
		rdc(REG_MAX_DELAY, MAX_DELAY_RST, RESP_OKAY, "max delay");
		rdc(REG_MIN_HOLD, MIN_HOLD_RST, RESP_OKAY, "min hold");
		rdc(8'h50, 32'h0, RESP_SLVERR, "unmapped");
		wr(REG_MAX_DELAY, 32'ha);
		rdc(REG_MAX_DELAY, 32'ha, RESP_OKAY, "max delay set");
		wr(REG_START_DELAY, 32'h4);
		$display("registers done");
	endtask : t_regs
	task automatic t_act();
		go(2'h0, 0);
		watch(2'b00, 50, 0, "early act");
		watch(2'b01, 100, 1, "act after delay");
		go(2'h1, 0);
		watch(2'b01, 50, 0, "hold running");
		watch(2'b00, 100, 1, "hold release");
		rdc(REG_ACT_CNT, 32'h1, RESP_OKAY, "act count");
		// Low start ON and activation ON so far: two entries, write pointer at two
		rdc(REG_LOG_IDX, 32'h22, RESP_OKAY, "log fill");
		rdc(REG_LOG_W1, 32'h10, RESP_OKAY, "log event");
		// Low start and activation, both ON and OFF, all selected after reset
		chk("events", 32'h451, {20'h0, evt_seen});
		chk("event stamp", 32'h1, stamp_gap);
		$display("activation done");
	endtask : t_act
	task automatic t_early();
		wr(REG_START_DELAY, 32'h14);
		go(2'h0, 0);
		watch(2'b00, 100, 0, "short low");
		go(2'h1, 0);
		watch(2'b00, 300, 0, "no act");
		$display("short low done");
	endtask : t_early
	task automatic t_zero();
		wr(REG_START_DELAY, 32'h0);
		go(2'h0, 0);
		// Comparator tick, state tick and the transition tick: up to 31 cycles
		watch(2'b01, 40, 1, "zero delay");
		go(2'h2, 0);
		watch(2'b01, 30, 0, "high running");
		go(2'h3, 0);
		watch(2'b00, 25, 1, "over release");
		$display("overcurrent done");
	endtask : t_zero
	task automatic t_max();
		go(2'h1, 20);
		go(2'h0, 0);
		watch(2'b01, 40, 1, "act");
		go(2'h1, 30);
		go(2'h2, 0);
		watch(2'b01, 90, 0, "inrush in hold");
		watch(2'b00, 50, 1, "max release");
		$display("max delay done");
	endtask : t_max
	task automatic t_block();
		@(posedge aclk) blk_req <= 1'b1;
		go(2'h1, 30);
		go(2'h0, 0);
		watch(2'b10, 40, 1, "blocked");
		rdc(REG_BLK_CNT, 32'h1, RESP_OKAY, "block count");
		rdc(REG_ACT_CNT, 32'h3, RESP_OKAY, "act total");
		wr(REG_CTRL, 32'h1);
		rdc(REG_ACT_CNT, 32'h0, RESP_OKAY, "act cleared");
		rdc(REG_BLK_CNT, 32'h0, RESP_OKAY, "block cleared");
		$display("block done");
	endtask : t_block
	// Main sequence; reset held for ten edges
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_act();
		t_early();
		t_zero();
		t_max();
		t_block();
		complete_run();
	end
endmodule : cold_load_pickup_timing_bench
